// ### hw/pbs_sequencer.sv
/*
 * Pushbutton power sequencer: debounces the button, drives the open-drain
 * supply enable and power-down interrupt, and watches the shutdown input.
 * Assumes pull-ups on both open-drain pins and a 10 MHz clock.
 */
//
// Functional notes
// - Enable asserts after button held low 32ms plus on extension; high restarts.
// - Asserting the enable starts a 512ms blanking timer.
// - Shutdown still low at blanking end aborts power-on, enable drops then.
// - During blanking both shutdown input and button are ignored.
// - After blanking, button release is debounced for 32ms before monitoring.
// - Falling button starts 32ms debounce; interrupt asserts after; high resets.
// - Interrupt stays asserted at least 32ms even if button released, unless the shutdown input qualifies first.
// - Button low after 32ms starts power-down timer; early release ends interrupt.
// - Interrupt alone never changes the enable.
// - Holding for 16 power-down cycles releases enable and interrupt at once.
// - In normal operation shutdown low held for 30us releases the enable.
// - After shutdown release, button is ignored for 256ms lockout.
// - After power-down, idle waits only for a new falling button edge.
// - Enable polarity is a build option, active-high or active-low.
// - Shutdown low counts after persisting 30us; enable releases then.
// - With no off extension, forced power-down hold time is 64ms.
// - Forced power-down hold time is 64ms plus the off extension rounded down to a multiple of 16ms.
// - Interrupt stays asserted while the button stays pressed, until the power-down timer ends.
// - At reset the enable is deasserted and the interrupt released.
`timescale 1ns/100ps

module pbs_sequencer
    import pbs_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES,
    parameter logic EN_ACTIVE_HIGH = 1'b1,
    parameter int unsigned on_time_extension = 0,
    parameter int unsigned off_time_extension = 0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pushbutton and shutdown inputs
    input wire logic pushbutton_n,
    input wire logic shutdown_n,
    // Open-drain supply enable
    input wire logic en_in,
    output pbs_od_s en_pin,
    // Open-drain power-down interrupt
    input wire logic int_in,
    output pbs_od_s int_pin
);

    localparam logic [TMR_W-1:0] ON_LAST = TMR_W'(DB_ON_MS + on_time_extension - 1);
    localparam logic [TMR_W-1:0] BLANK_LAST = TMR_W'(BLANK_MS - 1);
    localparam logic [TMR_W-1:0] REL_LAST = TMR_W'(REL_DB_MS - 1);
    localparam logic [TMR_W-1:0] OFF_LAST = TMR_W'(DB_OFF_MS - 1);
    localparam logic [TMR_W-1:0] INT_LAST = TMR_W'(INT_MIN_MS - 1);
    localparam logic [TMR_W-1:0] LOCK_LAST = TMR_W'(LOCKOUT_MS - 1);
    localparam int unsigned PD_CYC_MS = off_time_extension / PD_CYCLES;
    localparam int unsigned PD_EXT_MS = PD_CYC_MS * PD_CYCLES;
    localparam logic [TMR_W-1:0] PD_LAST = TMR_W'(PD_EXT_MS - 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);
    localparam logic [KILL_W-1:0] KILL_FULL = KILL_W'(KILL_QUAL_CYC);
    localparam logic PD_NONE = (PD_EXT_MS == 0);

    pbs_state_e st_r;
    pbs_state_e st_nxt;
    logic pb_lvl;
    logic kill_lvl;
    logic pb_prev_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic tick;
    logic [TMR_W-1:0] tmr_r;
    logic tmr_clr;
    logic [KILL_W-1:0] kill_cnt_r;
    logic kill_valid;
    logic en_on_r;
    logic int_on_r;
    logic en_on_nxt;
    logic int_on_nxt;
    logic pb_low;
    logic pb_fall;
    logic monitor;
    logic on_done;
    logic blank_done;
    logic rel_done;
    logic off_done;
    logic int_done;
    logic pd_done;
    logic lock_done;

    // --------------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------------
    pbs_sync #(.RST_VAL(1'b1)) u_pb_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(pushbutton_n),
        .lvl(pb_lvl)
    );

    pbs_sync #(.RST_VAL(1'b0)) u_kill_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(shutdown_n),
        .lvl(kill_lvl)
    );

    assign pb_low = !pb_lvl;
    assign pb_fall = pb_prev_r && !pb_lvl;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pb_prev_r <= 1'b1;
        end else begin
            pb_prev_r <= pb_lvl;
        end
    end

    // --------------------------------------------------------------------
    // Millisecond time base, realigned whenever a timer restarts
    // --------------------------------------------------------------------
    assign tick = (tick_cnt_r == TICK_LAST);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_r <= '0;
        end else if (tmr_clr || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end

    // --------------------------------------------------------------------
    // Millisecond timer shared by all states
    // --------------------------------------------------------------------
    assign tmr_clr = (st_nxt != st_r) || ((st_r == ST_REL_DB) && pb_low);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmr_r <= '0;
        end else if (tmr_clr) begin
            tmr_r <= '0;
        end else if (tick) begin
            tmr_r <= tmr_r + 1'b1;
        end
    end

    assign on_done = tick && (tmr_r == ON_LAST);
    assign blank_done = tick && (tmr_r == BLANK_LAST);
    assign rel_done = tick && (tmr_r == REL_LAST);
    assign off_done = tick && (tmr_r == OFF_LAST);
    assign int_done = tick && (tmr_r == INT_LAST);
    assign pd_done = tick && (tmr_r == PD_LAST);
    assign lock_done = tick && (tmr_r == LOCK_LAST);

    // --------------------------------------------------------------------
    // Shutdown input qualification
    // --------------------------------------------------------------------
    assign kill_valid = (kill_cnt_r == KILL_FULL);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kill_cnt_r <= '0;
        end else if (kill_lvl) begin
            kill_cnt_r <= '0;
        end else if (!kill_valid) begin
            kill_cnt_r <= kill_cnt_r + 1'b1;
        end
    end

    assign monitor = (st_r == ST_REL_DB) || (st_r == ST_RUN) || (st_r == ST_OFF_DB) ||
                     (st_r == ST_INT_MIN) || (st_r == ST_PDT);

    // --------------------------------------------------------------------
    // Sequencer state machine
    // --------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        en_on_nxt = en_on_r;
        int_on_nxt = int_on_r;
        if (monitor && kill_valid) begin
            st_nxt = ST_LOCK;
            en_on_nxt = 1'b0;
            int_on_nxt = 1'b0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    if (pb_fall) begin
                        st_nxt = ST_ON_DB;
                    end
                end
                ST_ON_DB: begin
                    if (!pb_low) begin
                        st_nxt = ST_IDLE;
                    end else if (on_done) begin
                        st_nxt = ST_BLANK;
                        en_on_nxt = 1'b1;
                    end
                end
                ST_BLANK: begin
                    if (blank_done) begin
                        if (!kill_lvl) begin
                            st_nxt = ST_LOCK;
                            en_on_nxt = 1'b0;
                        end else begin
                            st_nxt = ST_REL_DB;
                        end
                    end
                end
                ST_REL_DB: begin
                    if (rel_done && !pb_low) begin
                        st_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (pb_low) begin
                        st_nxt = ST_OFF_DB;
                    end
                end
                ST_OFF_DB: begin
                    if (!pb_low) begin
                        st_nxt = ST_RUN;
                    end else if (off_done) begin
                        st_nxt = ST_INT_MIN;
                        int_on_nxt = 1'b1;
                    end
                end
                ST_INT_MIN: begin
                    if (int_done) begin
                        if (!pb_low) begin
                            st_nxt = ST_RUN;
                            int_on_nxt = 1'b0;
                        end else if (PD_NONE) begin
                            st_nxt = ST_IDLE;
                            en_on_nxt = 1'b0;
                            int_on_nxt = 1'b0;
                        end else begin
                            st_nxt = ST_PDT;
                        end
                    end
                end
                ST_PDT: begin
                    if (!pb_low) begin
                        st_nxt = ST_RUN;
                        int_on_nxt = 1'b0;
                    end else if (pd_done) begin
                        st_nxt = ST_IDLE;
                        en_on_nxt = 1'b0;
                        int_on_nxt = 1'b0;
                    end
                end
                ST_LOCK: begin
                    if (lock_done) begin
                        st_nxt = ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_on_r <= 1'b0;
            int_on_r <= 1'b0;
        end else begin
            en_on_r <= en_on_nxt;
            int_on_r <= int_on_nxt;
        end
    end

    // --------------------------------------------------------------------
    // Open-drain pin drivers
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_pin <= '{o: 1'b0, oe: EN_ACTIVE_HIGH};
            int_pin <= '{o: 1'b0, oe: 1'b0};
        end else begin
            en_pin.o <= 1'b0;
            en_pin.oe <= en_on_nxt ^ EN_ACTIVE_HIGH;
            int_pin.o <= 1'b0;
            int_pin.oe <= int_on_nxt;
        end
    end

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    en_rise_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(en_on_r) |-> $past(st_r) == ST_ON_DB && $past(pb_low) && $past(tick))
        else $error("Enable rose without a full qualified press.");

    blank_start_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(en_on_r) |-> st_r == ST_BLANK && tmr_r == '0)
        else $error("Blanking did not start with the enable.");

    abort_on_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == ST_BLANK && blank_done && !kill_lvl) |=> !en_on_r && en_pin.oe == EN_ACTIVE_HIGH)
        else $error("Power-on not aborted with shutdown input low.");

    blank_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == ST_BLANK && !blank_done) |=> st_r == ST_BLANK && en_on_r)
        else $error("Blanking window left early.");

    rel_db_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == ST_REL_DB && pb_low && !kill_valid) |=> st_r == ST_REL_DB && tmr_r == '0)
        else $error("Release debounce did not restart.");

    int_min_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == ST_INT_MIN && !int_done && !kill_valid) |=> int_on_r && int_pin.oe)
        else $error("Interrupt dropped before its minimum width.");

    int_keep_en_a: assert property (@(posedge clk) disable iff (!nrst)
        ($fell(int_on_r) && !$past(pb_low) && !$past(kill_valid)) |-> en_on_r)
        else $error("Enable changed with the interrupt alone.");

    int_rise_en_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(int_on_r) |-> en_on_r && $stable(en_on_r))
        else $error("Enable changed as the interrupt asserted.");

    pd_release_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == ST_PDT && pb_low && pd_done && !kill_valid) |=> !en_on_r && !int_on_r
        ##1 !int_pin.oe)
        else $error("Long press did not release both outputs.");

    kill_off_a: assert property (@(posedge clk) disable iff (!nrst)
        (monitor && kill_valid) |=> st_r == ST_LOCK && !en_on_r)
        else $error("Shutdown input did not release the enable.");

    lockout_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == ST_LOCK && !lock_done) |=> st_r == ST_LOCK && !en_on_r)
        else $error("Lockout left early.");

    kill_qual_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(kill_valid) |-> !kill_lvl && $past(kill_cnt_r) == KILL_FULL - 1'b1)
        else $error("Shutdown input qualified at the wrong time.");

endmodule

// ### hw/pbs_pkg.sv
/*
 * Package for the pushbutton power sequencer: timing constants, state
 * enumeration and the open-drain pin carrier.
 * Assumes a 10 MHz system clock and millisecond timer resolution.
 */
package pbs_pkg;

    // --------------------------------------------------------------------
    // Clock and time base
    // --------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned KILL_QUAL_NS = 30000;
    localparam int unsigned KILL_QUAL_CYC =
        (KILL_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // --------------------------------------------------------------------
    // Timer lengths in milliseconds
    // --------------------------------------------------------------------
    localparam int unsigned TMR_W = 16;
    localparam int unsigned DB_ON_MS = 32;
    localparam int unsigned BLANK_MS = 512;
    localparam int unsigned REL_DB_MS = 32;
    localparam int unsigned DB_OFF_MS = 32;
    localparam int unsigned INT_MIN_MS = 32;
    localparam int unsigned PD_MIN_MS = 64;
    localparam int unsigned LOCKOUT_MS = 256;
    localparam int unsigned PD_CYCLES = 16;
    localparam int unsigned KILL_W = 9;
    localparam int unsigned TICK_W = 16;

    // --------------------------------------------------------------------
    // Types
    // --------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ON_DB,
        ST_BLANK,
        ST_REL_DB,
        ST_RUN,
        ST_OFF_DB,
        ST_INT_MIN,
        ST_PDT,
        ST_LOCK
    } pbs_state_e;

    typedef struct packed {
        logic o;
        logic oe;
    } pbs_od_s;

endpackage

// ### hw/pbs_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk; the output changes only when
 * the second and third stages agree.
 */
`timescale 1ns/100ps

module pbs_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pin and filtered level
    input wire logic pin,
    output logic lvl
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // --------------------------------------------------------------------
    // Synchroniser chain
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // --------------------------------------------------------------------
    // Agreement filter
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lvl <= RST_VAL;
        end else if (s2_r == s3_r) begin
            lvl <= s3_r;
        end
    end

endmodule

// ### verif/pbs_host_model.sv
/*
 * Behavioural model of the system processor on the far side of the sequencer.
 * Assumes open-drain pins already resolved to levels by the bench.
 */
`timescale 1ns/100ps

module pbs_host_model #(
    parameter logic EN_ACTIVE_HIGH = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Resolved pin levels
    input wire logic en_lvl,
    input wire logic int_lvl,
    // Behaviour controls
    input wire logic raise_en,
    input wire logic ack_en,
    input wire logic [15:0] raise_dly,
    input wire logic [15:0] ack_dly,
    // Shutdown drive
    output logic shutdown_n
);
    // ------------------------------------------------------------------
    // Processor power-up and power-down behaviour
    // ------------------------------------------------------------------
    logic [15:0] cnt_r;
    logic pend_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shutdown_n <= 1'b0;
            cnt_r <= 16'h0000;
            pend_r <= 1'b0;
        end else if (en_lvl != EN_ACTIVE_HIGH) begin
            shutdown_n <= 1'b0;
            cnt_r <= 16'h0000;
            pend_r <= 1'b0;
        end else if (!shutdown_n && !pend_r) begin
            if (raise_en && cnt_r >= raise_dly) begin
                shutdown_n <= 1'b1;
                cnt_r <= 16'h0000;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end else if (pend_r || (ack_en && !int_lvl)) begin
            pend_r <= 1'b1;
            if (cnt_r >= ack_dly) begin
                shutdown_n <= 1'b0;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end
endmodule

// ### verif/test_pbs_sequencer.sv
/*
 * Self-checking bench for the pushbutton power sequencer.
 * Assumes a 1 ms tick of 10 clocks and a processor model on the shutdown pin.
 */
`timescale 1ns/100ps

module test_pbs_sequencer;
    import pbs_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam logic EAH = 1'b1;
    typedef struct packed {
        logic [1:0] lvl;
        int lo;
        int hi;
    } pbs_note_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pushbutton_n = 1'b1;
    logic raise_en = 1'b0;
    logic ack_en = 1'b0;
    logic [15:0] raise_dly = 16'h0064;
    logic [15:0] ack_dly = 16'h0064;
    logic shutdown_n;
    logic en_lvl;
    logic int_lvl;
    pbs_od_s en_pin;
    pbs_od_s int_pin;
    logic en_b_lvl;
    logic int_b_lvl;
    pbs_od_s en_b_pin;
    pbs_od_s int_b_pin;
    int cyc = 0;
    int fails = 0;
    int n_checks = 0;
    logic [31:0] rnd = 32'h0001_732C;
    logic [1:0] prev_lvl = {~EAH, 1'b1};
    pbs_note_s notes[$];

    assign en_lvl = en_pin.oe ? en_pin.o : 1'b1;
    assign int_lvl = int_pin.oe ? int_pin.o : 1'b1;
    assign en_b_lvl = en_b_pin.oe ? en_b_pin.o : 1'b1;
    assign int_b_lvl = int_b_pin.oe ? int_b_pin.o : 1'b1;
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    pbs_sequencer #(.TICK_LEN(10), .EN_ACTIVE_HIGH(EAH), .on_time_extension(0),
        .off_time_extension(32)) pbs_sequencer_i (.clk(clk), .nrst(nrst),
        .pushbutton_n(pushbutton_n), .shutdown_n(shutdown_n), .en_in(en_lvl),
        .en_pin(en_pin), .int_in(int_lvl), .int_pin(int_pin));

    pbs_sequencer #(.TICK_LEN(10), .EN_ACTIVE_HIGH(~EAH), .on_time_extension(0),
        .off_time_extension(32)) pbs_sequencer_low_i (.clk(clk), .nrst(nrst),
        .pushbutton_n(pushbutton_n), .shutdown_n(shutdown_n), .en_in(en_b_lvl),
        .en_pin(en_b_pin), .int_in(int_b_lvl), .int_pin(int_b_pin));

    pbs_host_model #(.EN_ACTIVE_HIGH(EAH)) pbs_host_model_i (.clk(clk), .nrst(nrst),
        .en_lvl(en_lvl), .int_lvl(int_lvl), .raise_en(raise_en), .ack_en(ack_en),
        .raise_dly(raise_dly), .ack_dly(ack_dly), .shutdown_n(shutdown_n));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic rand_in(input int lo, input int span, output int v);
        rnd = {rnd[30:0], 1'b0} ^ (rnd[31] ? 32'h0040_0007 : 32'h0000_0000);
        v = lo + int'(rnd % span);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic press(input int hold);
        pushbutton_n = 1'b0;
        tick(hold);
        pushbutton_n = 1'b1;
    endtask

    task automatic expect_lvl(input logic en, input logic irq, input int lo, input int hi);
        notes.push_back(pbs_note_s'{{en, irq}, cyc + lo, cyc + hi});
    endtask

    task automatic cmp_lvl(input logic [1:0] got, input logic [1:0] want);
        n_checks++;
        if (got !== want) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic cmp_cyc(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("BAD %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic done(input string name);
        cmp_cyc(notes.size(), 0, 0);
        $display("test %s done", name);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        pbs_note_s n;
        if (nrst && {en_b_lvl, int_b_lvl} !== {~en_lvl, int_lvl}) begin
            cmp_lvl({en_b_lvl, int_b_lvl}, {~en_lvl, int_lvl});
        end
        if (nrst && {en_lvl, int_lvl} !== prev_lvl) begin
            if (notes.size() == 0) begin
                cmp_lvl({en_lvl, int_lvl}, prev_lvl);
            end else begin
                n = notes.pop_front();
                cmp_lvl({en_lvl, int_lvl}, n.lvl);
                cmp_cyc(cyc, n.lo, n.hi);
            end
            cmp_lvl({en_b_lvl, int_b_lvl}, {~en_lvl, int_lvl});
            prev_lvl = {en_lvl, int_lvl};
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic power_on(input logic raise);
        int g;
        rand_in(20, 250, g);
        press(g);
        tick(50);
        raise_en = raise;
        rand_in(100, 3900, g);
        raise_dly = 16'(g);
        expect_lvl(EAH, 1'b1, 320, 336);
        if (!raise) begin
            expect_lvl(~EAH, 1'b1, 5440, 5460);
        end
        press(1000);
        tick(raise ? 4850 : 7100);
    endtask

    initial begin
        int g;
        tick(5);
        cmp_lvl({en_lvl, int_lvl}, {~EAH, 1'b1});
        cmp_lvl({en_b_lvl, int_b_lvl}, {EAH, 1'b1});
        nrst = 1'b1;
        tick(20);
        done("reset");
        power_on(1'b1);
        done("power_on");
        rand_in(20, 250, g);
        press(g);
        tick(100);
        expect_lvl(EAH, 1'b0, 320, 336);
        expect_lvl(EAH, 1'b1, 640, 660);
        press(340);
        tick(400);
        done("short_press");
        rand_in(600, 200, g);
        ack_dly = 16'(g);
        ack_en = 1'b1;
        expect_lvl(EAH, 1'b0, 320, 336);
        expect_lvl(EAH, 1'b1, 800, 816);
        expect_lvl(~EAH, 1'b1, 620 + g, 660 + g);
        press(800);
        tick(g);
        ack_en = 1'b0;
        press(400);
        tick(2500);
        done("kill");
        power_on(1'b0);
        done("abort");
        power_on(1'b1);
        expect_lvl(EAH, 1'b0, 320, 336);
        expect_lvl(~EAH, 1'b1, 950, 976);
        press(1200);
        tick(500);
        done("forced_off");
        results();
    end

    initial begin
        #(60000 * 100);
        fails++;
        results();
    end
endmodule
